// ### srf_pkg.sv
// Constants, types and register map of the source-route frame filter.
// Assumes a 40 MHz system clock and a 10 Mbit/s token bus link.
package srf_pkg;
	// Timing
	localparam int CLK_NS = 25;
	localparam int SER_BIT_NS = 100;
	localparam logic [2:0] BIT_DIV = 3'(SER_BIT_NS / CLK_NS);
	localparam int TOKEN_RESP_BITS = 105;
	localparam int TOKEN_RESP_NS = TOKEN_RESP_BITS * SER_BIT_NS;
	localparam int TOKEN_RESP_CYC = TOKEN_RESP_NS / CLK_NS;
	localparam int REPLY_RESP_BITS = 498;
	localparam int REPLY_RESP_NS = REPLY_RESP_BITS * SER_BIT_NS;
	localparam int REPLY_RESP_CYC = REPLY_RESP_NS / CLK_NS;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SRC_SEG = 8'h04;
	localparam logic [7:0] OFS_TGT_SEG = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_ACC_CNT = 8'h14;
	localparam logic [7:0] OFS_TX = 8'h18;
	// Field positions
	localparam int CTRL_RECOG_BIT = 0;
	localparam int CTRL_PRED_BIT = 1;
	localparam int TX_LAST_BIT = 8;
	localparam int RC_BCAST_LSB = 5;
	localparam int RC_LEN_LSB = 0;
	localparam int ST_SR_HIT_BIT = 0;
	localparam int ST_ACC_BIT = 1;
	localparam int ST_KIND_LSB = 2;
	localparam int ST_LEN_LSB = 8;
	localparam logic [4:0] RC_OCTETS = 5'h02;
	// Reset values (initialization table)
	localparam logic [1:0] RST_CTRL = 2'h0;
	localparam logic [15:0] RST_SRC_SEG = 16'h0000;
	localparam logic [15:0] RST_TGT_SEG = 16'h0000;
	localparam logic [15:0] RST_MASK = 16'hF0FF;

	typedef enum logic [1:0] {
		BC_NONE = 2'h0,
		BC_ALL = 2'h1,
		BC_LIMITED = 2'h2
	} bcast_kind_e;

	typedef enum logic [4:0] {
		PH_IDLE = 5'h01,
		PH_RC0 = 5'h02,
		PH_RC1 = 5'h04,
		PH_RD_HI = 5'h08,
		PH_RD_LO = 5'h10
	} phase_e;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} rx_beat_s;

	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} tx_beat_s;

	function automatic bcast_kind_e bcast_kind(input logic [2:0] code);
		if (!code[2]) begin
			return BC_NONE;
		end
		return code[1] ? BC_LIMITED : BC_ALL;
	endfunction
endpackage

// ### srf_serializer.sv
// Octet serializer toward the token bus, least significant bit first.
// Assumes the caller holds a beat until ready_o; one bit per BIT_DIV clocks.
`timescale 1ns/100ps
module srf_serializer
	import srf_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire tx_beat_s beat_i,
	output logic ready_o,
	output logic bit_o,
	output logic bit_en_o,
	output logic frame_done_o
);
	typedef struct packed {
		logic busy;
		logic last;
		logic [7:0] shreg;
		logic [2:0] bitn;
		logic [2:0] div;
		logic bit_out;
		logic bit_en;
		logic done;
	} ser_state_s;

	ser_state_s st;
	ser_state_s next_st;

	always_comb begin
		next_st = st;
		next_st.bit_en = 1'b0;
		next_st.done = 1'b0;
		if (!st.busy) begin
			if (beat_i.valid) begin
				next_st.busy = 1'b1;
				next_st.last = beat_i.last;
				next_st.shreg = beat_i.data;
				next_st.bitn = 3'h0;
				next_st.div = 3'h0;
			end
		end else if (st.div == BIT_DIV - 3'h1) begin
			next_st.div = 3'h0;
			next_st.bit_out = st.shreg[0];
			next_st.bit_en = 1'b1;
			next_st.shreg = {1'b0, st.shreg[7:1]};
			next_st.bitn = st.bitn + 3'h1;
			if (st.bitn == 3'h7) begin
				next_st.busy = 1'b0;
				next_st.done = st.last;
			end
		end else begin
			next_st.div = st.div + 3'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign ready_o = !st.busy;
	assign bit_o = st.bit_out;
	assign bit_en_o = st.bit_en;
	assign frame_done_o = st.done;

	sequence s_load;
		!st.busy && beat_i.valid;
	endsequence

	property p_lsb_first;
		logic [7:0] b;
		@(posedge clk_i) disable iff (rst_i)
		(s_load, b = beat_i.data) |-> ##5 (bit_en_o && bit_o == b[0])
			##4 (bit_en_o && bit_o == b[1]);
	endproperty
	a_lsb_first: assert property (p_lsb_first) else $error("Bit order not LSB first");
endmodule

// ### srf_filter.sv
// Source-route receive filter with Wishbone registers and transmit path.
// Assumes an upstream deframer: rx_i carries only routing field octets.
`timescale 1ns/100ps
module srf_filter
	import srf_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic frame_start_i,
	input wire logic routing_info_indicator_i,
	input wire rx_beat_s rx_i,
	input wire logic frame_end_delimiter_i,
	input wire logic addr_match_i,
	input wire logic token_for_me_i,
	input wire logic request_reply_frame_i,
	output logic frame_accept_o,
	output logic preamble_start_o,
	output logic serial_bit_o,
	output logic serial_bit_en_o,
	output logic tx_frame_done_o
);
	localparam int TOK_LIM = TOKEN_RESP_CYC;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic [1:0] ctrl;
		logic [15:0] src_seg;
		logic [15:0] tgt_seg;
		logic [15:0] mask;
		phase_e phase;
		logic routing_info_indicator;
		logic [4:0] left;
		logic [7:0] rd_hi;
		logic prev_src;
		logic sr_hit;
		logic [2:0] bcast;
		logic [4:0] rlen;
		logic last_acc;
		logic last_hit;
		logic [15:0] acc_cnt;
		logic accept;
		tx_beat_s tx;
		logic resp_pend;
		logic preamble;
	} rf_state_s;

	rf_state_s st;
	rf_state_s next_st;
	logic tx_ready;
	logic [15:0] rd_word;
	logic src_hit;
	logic tgt_hit;
	logic wb_req;
	logic wr_ok;

	function automatic logic [15:0] lane_write(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0]) begin
			r[7:0] = wd[7:0];
		end
		if (sel[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	function automatic logic seg_match(input logic [15:0] rd,
		input logic [15:0] id, input logic [15:0] msk);
		return ((rd ^ id) & msk) == 16'h0000;
	endfunction

	function automatic logic [31:0] read_mux(input rf_state_s s, input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			OFS_CTRL: r[1:0] = s.ctrl;
			OFS_SRC_SEG: r[15:0] = s.src_seg;
			OFS_TGT_SEG: r[15:0] = s.tgt_seg;
			OFS_MASK: r[15:0] = s.mask;
			OFS_STATUS: begin
				r[ST_SR_HIT_BIT] = s.last_hit;
				r[ST_ACC_BIT] = s.last_acc;
				r[ST_KIND_LSB +: 2] = bcast_kind(s.bcast);
				r[ST_LEN_LSB +: 5] = s.rlen;
				r[TX_LAST_BIT + 8] = !tx_ready || s.tx.valid;
			end
			OFS_ACC_CNT: r[15:0] = s.acc_cnt;
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	srf_serializer u_ser (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.beat_i(st.tx),
		.ready_o(tx_ready),
		.bit_o(serial_bit_o),
		.bit_en_o(serial_bit_en_o),
		.frame_done_o(tx_frame_done_o)
	);

	assign rd_word = {st.rd_hi, rx_i.data};
	assign src_hit = seg_match(rd_word, st.src_seg, st.mask);
	assign tgt_hit = seg_match(rd_word, st.tgt_seg, st.mask);
	assign wb_req = cyc_i && stb_i && !st.ack;
	assign wr_ok = !(adr_i == OFS_TX && st.tx.valid);

	always_comb begin
		next_st = st;
		next_st.ack = 1'b0;
		next_st.accept = 1'b0;
		next_st.preamble = 1'b0;
		// Register bus
		if (wb_req && (!we_i || wr_ok)) begin
			next_st.ack = 1'b1;
			next_st.dat = we_i ? 32'h0000_0000 : read_mux(st, adr_i);
			if (we_i) begin
				case (adr_i)
					OFS_CTRL: begin
						if (sel_i[0]) begin
							next_st.ctrl = dat_i[1:0];
						end
					end
					OFS_SRC_SEG: next_st.src_seg = lane_write(st.src_seg, dat_i, sel_i);
					OFS_TGT_SEG: next_st.tgt_seg = lane_write(st.tgt_seg, dat_i, sel_i);
					OFS_MASK: next_st.mask = lane_write(st.mask, dat_i, sel_i);
					OFS_TX: begin
						if (sel_i[0]) begin
							next_st.tx.valid = 1'b1;
							next_st.tx.data = dat_i[7:0];
							next_st.tx.last = sel_i[1] && dat_i[TX_LAST_BIT];
						end
					end
					default: next_st.dat = 32'h0000_0000;
				endcase
			end
		end
		// Transmit handoff, bytes unaltered
		if (st.tx.valid && tx_ready) begin
			next_st.tx.valid = 1'b0;
		end
		// Routing field scan
		if (frame_start_i) begin
			next_st.phase = PH_RC0;
			next_st.routing_info_indicator = routing_info_indicator_i;
			next_st.sr_hit = 1'b0;
			next_st.prev_src = 1'b0;
			next_st.left = 5'h00;
		end else if (rx_i.valid) begin
			case (st.phase)
				PH_IDLE: next_st.phase = PH_IDLE;
				PH_RC0: begin
					next_st.bcast = rx_i.data[RC_BCAST_LSB +: 3];
					next_st.rlen = rx_i.data[RC_LEN_LSB +: 5];
					next_st.left = rx_i.data[RC_LEN_LSB +: 5] - 5'h01;
					next_st.phase = PH_RC1;
				end
				PH_RC1: begin
					// Second control octet carries nothing the filter uses
					next_st.left = st.left - 5'h01;
					next_st.phase = (st.rlen > RC_OCTETS) ? PH_RD_HI : PH_IDLE;
				end
				PH_RD_HI: begin
					next_st.rd_hi = rx_i.data;
					next_st.left = st.left - 5'h01;
					next_st.phase = (st.left > 5'h01) ? PH_RD_LO : PH_IDLE;
				end
				PH_RD_LO: begin
					if (st.prev_src && tgt_hit) begin
						next_st.sr_hit = 1'b1;
					end
					next_st.prev_src = src_hit;
					next_st.left = st.left - 5'h01;
					next_st.phase = (st.left > 5'h01) ? PH_RD_HI : PH_IDLE;
				end
				default: next_st.phase = PH_IDLE;
			endcase
		end
		// Decision at end of frame, same test for every broadcast kind
		if (frame_end_delimiter_i) begin
			next_st.phase = PH_IDLE;
			next_st.last_hit = st.sr_hit && st.routing_info_indicator;
			next_st.accept = addr_match_i
				|| (st.ctrl[CTRL_RECOG_BIT] && st.routing_info_indicator && st.sr_hit);
			next_st.last_acc = next_st.accept;
			if (next_st.accept) begin
				next_st.acc_cnt = st.acc_cnt + 16'h0001;
			end
			next_st.resp_pend = token_for_me_i
				|| (request_reply_frame_i && st.ctrl[CTRL_PRED_BIT]);
		end
		// Answer starts on the cycle after the pending flag
		if (st.resp_pend) begin
			// New delimiter keeps its own request
			if (!frame_end_delimiter_i) begin
				next_st.resp_pend = 1'b0;
			end
			next_st.preamble = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
			st.phase <= PH_IDLE;
			st.ctrl <= RST_CTRL;
			st.src_seg <= RST_SRC_SEG;
			st.tgt_seg <= RST_TGT_SEG;
			st.mask <= RST_MASK;
		end else begin
			st <= next_st;
		end
	end

	assign dat_o = st.dat;
	assign ack_o = st.ack;
	assign frame_accept_o = st.accept;
	assign preamble_start_o = st.preamble;

	// Checks
	logic [11:0] reply_wait;
	always_ff @(posedge clk_i) begin
		if (rst_i || preamble_start_o) begin
			reply_wait <= 12'h000;
		end else if (st.resp_pend || reply_wait != 12'h000) begin
			reply_wait <= reply_wait + 12'h001;
		end
	end

	sequence s_designator_pair;
		st.phase == PH_RD_LO && rx_i.valid && st.prev_src && tgt_hit && !frame_start_i;
	endsequence

	property p_pair_hit;
		@(posedge clk_i) disable iff (rst_i)
		s_designator_pair |=> st.sr_hit;
	endproperty
	a_pair_hit: assert property (p_pair_hit) else $error("Pair missed");

	property p_hi_octet;
		@(posedge clk_i) disable iff (rst_i)
		(st.phase == PH_RD_HI && rx_i.valid && !frame_start_i && !frame_end_delimiter_i)
			|=> st.rd_hi == $past(rx_i.data) && st.phase != PH_RD_HI;
	endproperty
	a_hi_octet: assert property (p_hi_octet) else $error("Byte 0 not held");

	property p_mask_zero;
		@(posedge clk_i) disable iff (rst_i)
		(st.mask == 16'h0000) |-> src_hit && tgt_hit;
	endproperty
	a_mask_zero: assert property (p_mask_zero) else $error("Bridge bits compared");

	property p_recog_off;
		@(posedge clk_i) disable iff (rst_i)
		(frame_end_delimiter_i && !addr_match_i && !st.ctrl[CTRL_RECOG_BIT]) |=> !frame_accept_o;
	endproperty
	a_recog_off: assert property (p_recog_off) else $error("Accept while disabled");

	property p_route_accept;
		@(posedge clk_i) disable iff (rst_i)
		(frame_end_delimiter_i && st.ctrl[CTRL_RECOG_BIT] && st.routing_info_indicator && st.sr_hit)
			|=> frame_accept_o ##1 !frame_accept_o;
	endproperty
	a_route_accept: assert property (p_route_accept) else $error("Routed frame lost");

	property p_addr_accept;
		@(posedge clk_i) disable iff (rst_i)
		(frame_end_delimiter_i && addr_match_i) |=> frame_accept_o;
	endproperty
	a_addr_accept: assert property (p_addr_accept) else $error("Address frame lost");

	property p_length;
		@(posedge clk_i) disable iff (rst_i)
		(st.phase == PH_RC0 && rx_i.valid && !frame_start_i)
			|=> st.rlen == $past(rx_i.data[4:0]) ##1 $stable(st.rlen) || rx_i.valid;
	endproperty
	a_length: assert property (p_length) else $error("Length not captured");

	property p_set_value;
		@(posedge clk_i) disable iff (rst_i)
		(wb_req && we_i && adr_i == OFS_MASK && sel_i[1:0] == 2'h3)
			|=> st.mask == $past(dat_i[15:0]) && ack_o;
	endproperty
	a_set_value: assert property (p_set_value) else $error("Mask write lost");

	property p_tx_exact;
		@(posedge clk_i) disable iff (rst_i)
		(wb_req && we_i && adr_i == OFS_TX && sel_i[0] && wr_ok)
			|=> st.tx.valid && st.tx.data == $past(dat_i[7:0]);
	endproperty
	a_tx_exact: assert property (p_tx_exact) else $error("Tx byte altered");

	property p_token_resp;
		@(posedge clk_i) disable iff (rst_i)
		(frame_end_delimiter_i && token_for_me_i) |-> ##[1:TOK_LIM] preamble_start_o;
	endproperty
	a_token_resp: assert property (p_token_resp) else $error("Token answer late");

	property p_reply_resp;
		@(posedge clk_i) disable iff (rst_i)
		reply_wait <= 12'(REPLY_RESP_CYC);
	endproperty
	a_reply_resp: assert property (p_reply_resp) else $error("Reply answer late");

	property p_reply_gate;
		@(posedge clk_i) disable iff (rst_i)
		(frame_end_delimiter_i && !token_for_me_i && !st.ctrl[CTRL_PRED_BIT])
			|=> !st.resp_pend;
	endproperty
	a_reply_gate: assert property (p_reply_gate) else $error("Reply while off");

	property p_ctl_ignored;
		@(posedge clk_i) disable iff (rst_i)
		(st.phase == PH_RC1 && rx_i.valid && !frame_start_i)
			|=> $stable(st.bcast) && $stable(st.rlen);
	endproperty
	a_ctl_ignored: assert property (p_ctl_ignored) else $error("Control octet used");
endmodule

// ### srf_link_model.sv
// Far-side model: delivers routing octets of frames and collects serial bytes.
// Assumes a deframer before the filter, so only routing octets are sent.
`timescale 1ns/100ps
module srf_link_model
	import srf_pkg::*;
(
	input wire logic clk_i,
	input wire logic serial_bit_i,
	input wire logic serial_bit_en_i,
	output logic frame_start_o,
	output logic routing_info_indicator_o,
	output rx_beat_s rx_o,
	output logic frame_end_delimiter_o,
	output logic addr_match_o,
	output logic token_for_me_o,
	output logic request_reply_frame_o
);
	logic [7:0] shift_reg;
	int nbits;
	logic [7:0] got_q[$];

	initial begin
		frame_start_o = 1'b0;
		routing_info_indicator_o = 1'b0;
		rx_o = '0;
		frame_end_delimiter_o = 1'b0;
		addr_match_o = 1'b0;
		token_for_me_o = 1'b0;
		request_reply_frame_o = 1'b0;
		shift_reg = 8'h00;
		nbits = 0;
	end

	// Bytes rebuilt least significant bit first
	always @(posedge clk_i) begin
		if (serial_bit_en_i === 1'b1) begin
			shift_reg = {serial_bit_i, shift_reg[7:1]};
			nbits++;
			if (nbits == 8) begin
				got_q.push_back(shift_reg);
				nbits = 0;
			end
		end
	end

	// Control octets, then byte 0 before byte 1 of each designator
	task automatic send_frame(input logic routing_info_indicator, input logic [7:0] rc0, input logic [15:0] rd[$],
		input logic am, input logic tok, input logic rrf);
		logic [7:0] oct[$];
		// Second octet: direction zero on discovery, one on replies
		oct = {rc0, rc0[7] ? 8'h7F : 8'hFF};
		foreach (rd[i]) begin
			oct.push_back(rd[i][15:8]);
			oct.push_back(rd[i][7:0]);
		end
		frame_start_o <= 1'b1;
		routing_info_indicator_o <= routing_info_indicator;
		foreach (oct[i]) begin
			@(posedge clk_i);
			frame_start_o <= 1'b0;
			rx_o <= {1'b1, oct[i]};
		end
		@(posedge clk_i);
		rx_o <= {1'b0, ~rx_o.data};
		routing_info_indicator_o <= ~routing_info_indicator;
		frame_end_delimiter_o <= 1'b1;
		addr_match_o <= am;
		token_for_me_o <= tok;
		request_reply_frame_o <= rrf;
		@(posedge clk_i);
		frame_end_delimiter_o <= 1'b0;
		addr_match_o <= 1'b0;
		token_for_me_o <= 1'b0;
		request_reply_frame_o <= 1'b0;
	endtask
endmodule

// ### srf_filter_tb.sv
// Testbench of the source-route filter: registers, receive, response, transmit.
// Assumes srf_link_model on the link side and a 40 MHz clock.
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module srf_filter_tb
	import srf_pkg::*;
	;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o, rd_val;
	logic ack_o, frame_start_i, routing_info_indicator_i, frame_end_delimiter_i, addr_match_i;
	logic token_for_me_i, request_reply_frame_i, frame_accept_o, preamble_start_o;
	logic serial_bit_o, serial_bit_en_o, tx_frame_done_o;
	rx_beat_s rx_i;
	int errors = 0;
	int checked = 0;
	int acc_exp = 0;
	logic [15:0] rds[$];
	logic [2:0] bc[3] = '{3'b011, 3'b101, 3'b110};
	logic [31:0] pairs[4] = '{32'h1F234556, 32'h4B561A23, 32'h1A334B56, 32'h1A234B57};
	logic [7:0] txb[3] = '{8'hA5, 8'h3C, 8'h81};

	always #12.5 clk_i = ~clk_i;

	srf_filter u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
		.ack_o, .frame_start_i, .routing_info_indicator_i, .rx_i, .frame_end_delimiter_i,
		.addr_match_i, .token_for_me_i, .request_reply_frame_i, .frame_accept_o,
		.preamble_start_o, .serial_bit_o, .serial_bit_en_o, .tx_frame_done_o);

	srf_link_model u_link (.clk_i, .serial_bit_i(serial_bit_o), .serial_bit_en_i(serial_bit_en_o),
		.frame_start_o(frame_start_i), .routing_info_indicator_o(routing_info_indicator_i),
		.rx_o(rx_i), .frame_end_delimiter_o(frame_end_delimiter_i), .addr_match_o(addr_match_i),
		.token_for_me_o(token_for_me_i), .request_reply_frame_o(request_reply_frame_i));

	task automatic report_and_stop();
		if (errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= s;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 200);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (ack_o !== 1'b1) begin
			errors++;
			report_and_stop();
		end
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(a, 1'b1, d, 4'hF, rd_val);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(a, 1'b0, 32'h0, 4'hF, rd_val);
		`CHK(rd_val, e)
	endtask

	// Adjacent masked pair carrying source then target segment
	function automatic logic hit();
		logic r;
		r = 1'b0;
		for (int i = 0; i + 1 < rds.size(); i++) begin
			r |= ((rds[i] & 16'hF0FF) == 16'h1023) && ((rds[i + 1] & 16'hF0FF) == 16'h4056);
		end
		return r;
	endfunction

	task automatic frame(input logic routing_info_indicator, input logic [7:0] rc0, input logic am,
		input logic tok, input logic rrf, input logic e);
		u_link.send_frame(routing_info_indicator, rc0, rds, am, tok, rrf);
		@(posedge clk_i);
		`CHK(frame_accept_o, e)
		if (e) begin
			acc_exp++;
		end
	endtask

	// Bridge host: forward with own designator unless segment already visited
	task automatic bridge_fwd(input logic [15:0] nd, input logic [4:0] len);
		logic seen;
		seen = 1'b0;
		foreach (rds[i]) begin
			seen |= (rds[i] & 16'hF0FF) == (nd & 16'hF0FF);
		end
		if (!seen) begin
			rds.push_back(nd);
			frame(1'b1, {3'b100, len + 5'h02}, 1'b0, 1'b0, 1'b0, hit());
		end
	endtask

	task automatic wait_pre(input int lim, input logic e);
		logic seen;
		seen = 1'b0;
		for (int n = 0; n < lim && !seen; n++) begin
			@(posedge clk_i);
			seen = (preamble_start_o === 1'b1);
		end
		`CHK(seen, e)
	endtask

	initial begin
		#2000000;
		errors++;
		report_and_stop();
	end

	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(OFS_CTRL, 32'h0);
		rd(OFS_SRC_SEG, 32'h0);
		rd(OFS_TGT_SEG, 32'h0);
		rd(OFS_MASK, 32'h0000F0FF);
		rd(OFS_ACC_CNT, 32'h0);
		wb(OFS_MASK, 1'b1, 32'h0, 4'h1, rd_val);
		rd(OFS_MASK, 32'h0000F000);
		wr(OFS_MASK, 32'h0000F0FF);
		wr(8'h1C, 32'hFFFFFFFF);
		rd(8'h1C, 32'h0);
		wr(OFS_SRC_SEG, 32'h1023);
		wr(OFS_TGT_SEG, 32'h4056);
		wr(OFS_CTRL, 32'h1);
		rds = {16'h7AB1, 16'h1A23, 16'h4B56};
		foreach (bc[k]) begin
			frame(1'b1, {bc[k], 5'h08}, 1'b0, 1'b0, 1'b0, hit());
			wb(OFS_STATUS, 1'b0, 32'h0, 4'hF, rd_val);
			`CHK(rd_val[3:0], {2'(k), 2'b11})
			`CHK(rd_val[12:8], 5'h08)
			`CHK(rd_val[16], 1'b0)
		end
		foreach (pairs[i]) begin
			rds = {pairs[i][31:16], pairs[i][15:0]};
			frame(1'b1, 8'h86, 1'b0, 1'b0, 1'b0, hit());
		end
		wr(OFS_MASK, 32'h0);
		frame(1'b1, 8'h86, 1'b0, 1'b0, 1'b0, 1'b1);
		wr(OFS_MASK, 32'h0000F0FF);
		rds = {16'h1A23};
		frame(1'b1, 8'h84, 1'b0, 1'b0, 1'b0, 1'b0);
		bridge_fwd(16'h4B56, 5'h04);
		bridge_fwd(16'h1B23, 5'h06);
		frame(1'b1, 8'h06, 1'b0, 1'b0, 1'b0, hit());
		rds = {16'h1A23, 16'h4B56};
		frame(1'b0, 8'h06, 1'b0, 1'b0, 1'b0, 1'b0);
		wr(OFS_CTRL, 32'h0);
		frame(1'b1, 8'h86, 1'b0, 1'b0, 1'b0, 1'b0);
		frame(1'b1, 8'h86, 1'b1, 1'b0, 1'b0, 1'b1);
		rd(OFS_ACC_CNT, 32'(acc_exp));
		rds = {};
		frame(1'b0, 8'h02, 1'b0, 1'b1, 1'b0, 1'b0);
		wait_pre(TOKEN_RESP_CYC - 2, 1'b1);
		frame(1'b0, 8'h02, 1'b0, 1'b0, 1'b1, 1'b0);
		wait_pre(40, 1'b0);
		wr(OFS_CTRL, 32'h2);
		frame(1'b0, 8'h02, 1'b0, 1'b0, 1'b1, 1'b0);
		wait_pre(REPLY_RESP_CYC - 2, 1'b1);
		for (int i = 0; i < 3; i++) begin
			wb(OFS_TX, 1'b1, {23'h0, i == 2, txb[i]}, 4'h3, rd_val);
		end
		wb(OFS_STATUS, 1'b0, 32'h0, 4'hF, rd_val);
		`CHK(rd_val[16], 1'b1)
		for (int n = 0; n < 400 && tx_frame_done_o !== 1'b1; n++) begin
			@(posedge clk_i);
		end
		`CHK(tx_frame_done_o, 1'b1)
		@(posedge clk_i);
		`CHK(u_link.got_q.size(), 3)
		foreach (txb[i]) begin
			`CHK(u_link.got_q[i], txb[i])
		end
		report_and_stop();
	end
endmodule
